/* rtl/bcfi_core.sv */
// frame receiver, command dispatcher and reply sender for the binary command protocol
`timescale 1ns/1ps
// Overview of operation
// - command, type, bank, four value bytes
// - serial frame adds address and checksum
// - value is four bytes, MSB first
// - checksum is 8-bit sum incl. address
// - CAN frame drops address and checksum
// - reply: raddr, maddr, status, cmd, value, csum
// - reply checksum sums other reply bytes
// - CAN reply omits address and checksum
// - exactly one reply per addressed command
// - transmit only replies, never unsolicited
// - reply only after execution completes; a checksum error replies at once
// - status 100 ok, 101 stored
// - error status codes one to six
module bcfi_core (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic can_mode,
  input wire logic [7:0] module_addr,
  input wire logic [7:0] reply_addr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_frame_start,
  output logic cmd_valid,
  output logic [7:0] cmd_number,
  output logic [7:0] cmd_type,
  output logic [7:0] cmd_bank,
  output logic [31:0] cmd_value,
  input wire logic exec_done,
  input wire bcfi_pkg::bcfi_result_t exec_result,
  input wire logic [31:0] exec_value,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic tx_last,
  input wire logic tx_ready,
  output logic tx_drive
);
  import bcfi_pkg::*;

  typedef enum logic [1:0] {BCFI_RX, BCFI_EXEC, BCFI_TX} bcfi_state_t;
  bcfi_state_t state_r;
  logic [3:0] idx_r;
  logic [7:0] frame_r [0:BCFI_SER_FRAME_LEN-1];
  logic [7:0] reply_r [0:BCFI_SER_FRAME_LEN-1];
  logic [7:0] rx_sum;
  logic [7:0] tx_sum;
  logic [7:0] reply_sum;
  logic [3:0] pos;
  logic frame_end;
  logic csum_ok;
  logic addr_ok;
  logic [7:0] status_nxt;
  logic [3:0] tx_first;
  logic [3:0] tx_end;
  logic tx_fire;
  logic cmd_valid_r;

  // byte position within the serial layout; CAN bytes start at the command field,
  // and a frame-start byte always lands on the first field whatever the count says
  assign pos = (rx_frame_start ? BCFI_IDX_ADDR : idx_r) + (can_mode ? BCFI_CAN_OFFSET : 4'h0);
  assign frame_end = rx_valid && (state_r == BCFI_RX)
    && (pos == (can_mode ? BCFI_IDX_VAL3 : BCFI_IDX_CSUM));

  bcfi_sum8 u_rx_sum (
    .core_clk(core_clk),
    .rst(rst),
    // restart at every frame start and frame end so a dropped frame cannot leak into the next sum
    .clear(rx_frame_start || frame_end || (state_r != BCFI_RX)),
    .add_en(rx_valid && (state_r == BCFI_RX) && !frame_end),
    .add_byte(rx_byte),
    .sum(rx_sum)
  );

  assign csum_ok = can_mode || (rx_byte == rx_sum);
  assign addr_ok = can_mode || (frame_r[BCFI_IDX_ADDR] == module_addr);

  // receive framing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idx_r <= 4'h0;
    end else if (state_r != BCFI_RX || rx_frame_start) begin
      idx_r <= (state_r == BCFI_RX && rx_valid) ? 4'h1 : 4'h0;
    end else if (frame_end) begin
      idx_r <= 4'h0;
    end else if (rx_valid) begin
      idx_r <= idx_r + 4'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < BCFI_SER_FRAME_LEN; i++) begin
        frame_r[i] <= BCFI_RESET_BYTE;
      end
    end else if (rx_valid && state_r == BCFI_RX) begin
      frame_r[pos] <= rx_byte;
    end
  end

  // state sequencing: receive, execute, reply
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= BCFI_RX;
    end else begin
      case (state_r)
        BCFI_RX: begin
          if (frame_end && addr_ok) begin
            state_r <= csum_ok ? BCFI_EXEC : BCFI_TX;
          end
        end
        BCFI_EXEC: begin
          if (exec_done) begin
            state_r <= BCFI_TX;
          end
        end
        BCFI_TX: begin
          if (tx_fire && tx_last) begin
            state_r <= BCFI_RX;
          end
        end
        default: state_r <= BCFI_RX;
      endcase
    end
  end

  // command hand-off to the executor
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_valid_r <= 1'b0;
      cmd_number <= BCFI_RESET_BYTE;
      cmd_type <= BCFI_RESET_BYTE;
      cmd_bank <= BCFI_RESET_BYTE;
      cmd_value <= 32'h0000_0000;
    end else begin
      cmd_valid_r <= frame_end && addr_ok && csum_ok;
      if (frame_end) begin
        cmd_number <= frame_r[BCFI_IDX_CMD];
        cmd_type <= frame_r[BCFI_IDX_TYPE];
        cmd_bank <= frame_r[BCFI_IDX_BANK];
        cmd_value <= {frame_r[BCFI_IDX_VAL0], frame_r[BCFI_IDX_VAL0+4'h1], frame_r[BCFI_IDX_VAL0+4'h2],
          can_mode ? rx_byte : frame_r[BCFI_IDX_VAL3]};
      end
    end
  end
  assign cmd_valid = cmd_valid_r;

  always_comb begin
    case (exec_result)
      BCFI_RES_OK: status_nxt = BCFI_ST_OK;
      BCFI_RES_STORED: status_nxt = BCFI_ST_STORED;
      BCFI_RES_BAD_CMD: status_nxt = BCFI_ST_BAD_CMD;
      BCFI_RES_BAD_TYPE: status_nxt = BCFI_ST_BAD_TYPE;
      BCFI_RES_BAD_VALUE: status_nxt = BCFI_ST_BAD_VALUE;
      BCFI_RES_LOCKED: status_nxt = BCFI_ST_LOCKED;
      BCFI_RES_UNAVAIL: status_nxt = BCFI_ST_UNAVAIL;
      default: status_nxt = BCFI_ST_BAD_CMD;
    endcase
  end

  // reply assembly
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < BCFI_SER_FRAME_LEN; i++) begin
        reply_r[i] <= BCFI_RESET_BYTE;
      end
    end else if (state_r == BCFI_RX && frame_end && addr_ok && !csum_ok) begin
      reply_r[BCFI_RIDX_RADDR] <= reply_addr;
      reply_r[BCFI_RIDX_MADDR] <= module_addr;
      reply_r[BCFI_RIDX_STATUS] <= BCFI_ST_BAD_CSUM;
      reply_r[BCFI_RIDX_CMD] <= frame_r[BCFI_IDX_CMD];
      for (int i = BCFI_IDX_VAL0; i <= BCFI_IDX_VAL3; i++) begin
        reply_r[i] <= BCFI_RESET_BYTE;
      end
    end else if (state_r == BCFI_EXEC && exec_done) begin
      reply_r[BCFI_RIDX_RADDR] <= reply_addr;
      reply_r[BCFI_RIDX_MADDR] <= module_addr;
      reply_r[BCFI_RIDX_STATUS] <= status_nxt;
      reply_r[BCFI_RIDX_CMD] <= cmd_number;
      reply_r[BCFI_IDX_VAL0] <= exec_value[31:24];
      reply_r[BCFI_IDX_VAL0 + 4'h1] <= exec_value[23:16];
      reply_r[BCFI_IDX_VAL0 + 4'h2] <= exec_value[15:8];
      reply_r[BCFI_IDX_VAL3] <= exec_value[7:0];
    end
  end

  // reply sending
  assign tx_first = can_mode ? BCFI_RIDX_STATUS : BCFI_RIDX_RADDR;
  assign tx_end = can_mode ? BCFI_IDX_VAL3 : BCFI_IDX_CSUM;
  assign tx_fire = tx_valid && tx_ready;

  logic [3:0] tx_idx_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_idx_r <= 4'h0;
    end else if (state_r != BCFI_TX) begin
      tx_idx_r <= tx_first;
    end else if (tx_fire) begin
      tx_idx_r <= tx_idx_r + 4'h1;
    end
  end

  bcfi_sum8 u_tx_sum (
    .core_clk(core_clk),
    .rst(rst),
    .clear(state_r != BCFI_TX),
    .add_en(tx_fire && (tx_idx_r != BCFI_IDX_CSUM)),
    .add_byte(tx_byte),
    .sum(tx_sum)
  );

  assign tx_valid = (state_r == BCFI_TX);
  assign tx_drive = (state_r == BCFI_TX);
  assign tx_last = tx_valid && (tx_idx_r == tx_end);
  assign tx_byte = (tx_idx_r == BCFI_IDX_CSUM) ? tx_sum : reply_r[tx_idx_r];

  // independent sum of the stored reply bytes, held against the sent checksum
  always_comb begin
    reply_sum = BCFI_RESET_BYTE;
    for (int i = 0; i < BCFI_SER_FRAME_LEN - 1; i++) begin
      reply_sum = reply_sum + reply_r[i];
    end
  end

  property p_reply_first;
    @(posedge core_clk) disable iff (rst)
    ($rose(tx_valid) && !can_mode) |-> tx_byte == reply_addr;
  endproperty
  a_reply_first: assert property (p_reply_first)
    else $error("serial reply does not open with the reply address");

  property p_no_unsolicited;
    @(posedge core_clk) disable iff (rst)
    $rose(tx_drive) |-> ($past(frame_end && addr_ok && !csum_ok) || $past(exec_done && state_r == BCFI_EXEC));
  endproperty
  a_no_unsolicited: assert property (p_no_unsolicited)
    else $error("reply not caused by a command");

  property p_tx_hold;
    @(posedge core_clk) disable iff (rst)
    (tx_valid && !tx_ready) |=> tx_valid && $stable(tx_byte);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("reply byte changed before it was taken");

  property p_reply_csum;
    @(posedge core_clk) disable iff (rst)
    (tx_valid && !can_mode && tx_idx_r == BCFI_IDX_CSUM) |-> tx_byte == reply_sum;
  endproperty
  a_reply_csum: assert property (p_reply_csum)
    else $error("reply checksum wrong");

  property p_can_reply_open;
    @(posedge core_clk) disable iff (rst)
    ($rose(tx_valid) && can_mode) |-> tx_byte == reply_r[BCFI_RIDX_STATUS];
  endproperty
  a_can_reply_open: assert property (p_can_reply_open)
    else $error("CAN reply does not open with the status");

  property p_foreign_silent;
    @(posedge core_clk) disable iff (rst)
    (frame_end && !addr_ok) |=> !tx_drive && !cmd_valid;
  endproperty
  a_foreign_silent: assert property (p_foreign_silent)
    else $error("foreign frame answered");

  property p_bad_csum_status;
    @(posedge core_clk) disable iff (rst)
    (frame_end && addr_ok && !csum_ok) |=> (state_r == BCFI_TX) && reply_r[BCFI_RIDX_STATUS] == BCFI_ST_BAD_CSUM;
  endproperty
  a_bad_csum_status: assert property (p_bad_csum_status)
    else $error("checksum error not reported");

  property p_wait_exec;
    @(posedge core_clk) disable iff (rst)
    (state_r == BCFI_EXEC && !exec_done) |=> !tx_drive;
  endproperty
  a_wait_exec: assert property (p_wait_exec)
    else $error("reply before execution done");

  property p_ok_status;
    @(posedge core_clk) disable iff (rst)
    (state_r == BCFI_EXEC && exec_done && exec_result == BCFI_RES_OK) |=> reply_r[BCFI_RIDX_STATUS] == BCFI_ST_OK;
  endproperty
  a_ok_status: assert property (p_ok_status)
    else $error("success status not 100");

  property p_one_cmd;
    @(posedge core_clk) disable iff (rst)
    cmd_valid |=> !cmd_valid;
  endproperty
  a_one_cmd: assert property (p_one_cmd)
    else $error("command issued twice");

  property p_cmd_after_frame;
    @(posedge core_clk) disable iff (rst)
    cmd_valid |-> state_r == BCFI_EXEC && $past(csum_ok);
  endproperty
  a_cmd_after_frame: assert property (p_cmd_after_frame)
    else $error("command without good frame");

  property p_value_msb_first;
    @(posedge core_clk) disable iff (rst)
    cmd_valid |-> cmd_value[31:24] == frame_r[BCFI_IDX_VAL0] && cmd_value[7:0] == frame_r[BCFI_IDX_VAL3];
  endproperty
  a_value_msb_first: assert property (p_value_msb_first)
    else $error("command value byte order wrong");
endmodule : bcfi_core

/* rtl/bcfi_pkg.sv */
// package of frame layout, status codes and command-port constants for the frame interpreter
package bcfi_pkg;
  localparam int BCFI_SER_FRAME_LEN = 9;
  localparam int BCFI_CAN_FRAME_LEN = 7;
  localparam int BCFI_VALUE_BYTES = 4;
  localparam logic [3:0] BCFI_IDX_ADDR = 4'h0;
  localparam logic [3:0] BCFI_IDX_CMD = 4'h1;
  localparam logic [3:0] BCFI_IDX_TYPE = 4'h2;
  localparam logic [3:0] BCFI_IDX_BANK = 4'h3;
  localparam logic [3:0] BCFI_IDX_VAL0 = 4'h4;
  localparam logic [3:0] BCFI_IDX_VAL3 = 4'h7;
  localparam logic [3:0] BCFI_IDX_CSUM = 4'h8;
  localparam logic [3:0] BCFI_CAN_OFFSET = 4'h1;
  localparam logic [3:0] BCFI_RIDX_RADDR = 4'h0;
  localparam logic [3:0] BCFI_RIDX_MADDR = 4'h1;
  localparam logic [3:0] BCFI_RIDX_STATUS = 4'h2;
  localparam logic [3:0] BCFI_RIDX_CMD = 4'h3;
  localparam logic [7:0] BCFI_ST_OK = 8'h64;
  localparam logic [7:0] BCFI_ST_STORED = 8'h65;
  localparam logic [7:0] BCFI_ST_BAD_CSUM = 8'h01;
  localparam logic [7:0] BCFI_ST_BAD_CMD = 8'h02;
  localparam logic [7:0] BCFI_ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] BCFI_ST_BAD_VALUE = 8'h04;
  localparam logic [7:0] BCFI_ST_LOCKED = 8'h05;
  localparam logic [7:0] BCFI_ST_UNAVAIL = 8'h06;
  localparam logic [7:0] BCFI_RESET_BYTE = 8'h00;
  typedef enum logic [2:0] {
    BCFI_RES_OK,
    BCFI_RES_STORED,
    BCFI_RES_BAD_CMD,
    BCFI_RES_BAD_TYPE,
    BCFI_RES_BAD_VALUE,
    BCFI_RES_LOCKED,
    BCFI_RES_UNAVAIL
  } bcfi_result_t;
endpackage : bcfi_pkg

/* rtl/bcfi_sum8.sv */
// wrapping 8-bit additive checksum accumulator
`timescale 1ns/1ps
module bcfi_sum8 (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic add_en,
  input wire logic [7:0] add_byte,
  output logic [7:0] sum
);
  import bcfi_pkg::*;
  logic [7:0] sum_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sum_r <= BCFI_RESET_BYTE;
    end else if (clear) begin
      sum_r <= add_en ? add_byte : BCFI_RESET_BYTE;
    end else if (add_en) begin
      sum_r <= sum_r + add_byte;
    end
  end
  assign sum = sum_r;
endmodule : bcfi_sum8

/* testbench/bcfi_exec_model.sv */
// executor model that answers each decoded command after a set delay
`timescale 1ns/1ps
module bcfi_exec_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] delay,
  output logic exec_done
);
  initial begin
    exec_done = 1'b0;
    forever begin
      @(negedge core_clk);
      if (rst === 1'b0 && cmd_valid === 1'b1) begin
        repeat (delay) @(negedge core_clk);
        exec_done = 1'b1;
        @(negedge core_clk);
        exec_done = 1'b0;
      end
    end
  end
endmodule : bcfi_exec_model

/* testbench/tb_top.sv */
// self-checking bench for the frame interpreter core
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
  import bcfi_pkg::*;
  logic core_clk, rst, can_mode, rx_valid, rx_frame_start, exec_done, tx_valid, tx_last, tx_ready, tx_drive, cmd_valid;
  logic [7:0] module_addr, reply_addr, rx_byte, cmd_number, cmd_type, cmd_bank, tx_byte, dly;
  logic [31:0] cmd_value, exec_value;
  bcfi_result_t exec_result;
  int fail_count, check_count, cycles;
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  bcfi_core bcfi_core_i (.core_clk(core_clk), .rst(rst), .can_mode(can_mode), .module_addr(module_addr),
    .reply_addr(reply_addr), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_frame_start(rx_frame_start),
    .cmd_valid(cmd_valid), .cmd_number(cmd_number), .cmd_type(cmd_type), .cmd_bank(cmd_bank),
    .cmd_value(cmd_value), .exec_done(exec_done), .exec_result(exec_result), .exec_value(exec_value),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready), .tx_drive(tx_drive));
  bcfi_exec_model bcfi_exec_model_i (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .delay(dly),
    .exec_done(exec_done));
  function automatic logic [7:0] status_of(bcfi_result_t r);
    case (r)
      BCFI_RES_OK: return 8'h64;
      BCFI_RES_STORED: return 8'h65;
      BCFI_RES_BAD_CMD: return 8'h02;
      BCFI_RES_BAD_TYPE: return 8'h03;
      BCFI_RES_BAD_VALUE: return 8'h04;
      BCFI_RES_LOCKED: return 8'h05;
      default: return 8'h06;
    endcase
  endfunction : status_of
  task summarize;
    if (fail_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 20000) begin
      fail_count++;
      summarize();
    end
  end
  // one command frame, then its reply; the next frame waits for the whole reply
  task automatic run(input logic [7:0] a, c, t, b, input logic [31:0] v, input logic bad, input bcfi_result_t r);
    logic [7:0] fr[9];
    logic [7:0] e[$];
    logic [7:0] got[$];
    logic [7:0] ck;
    logic [31:0] rv;
    int n;
    exec_result = r;
    exec_value = $urandom;
    dly = 8'(1 + $urandom % 6);
    fr = '{a, c, t, b, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    for (int i = 0; i < 8; i++) fr[8] += fr[i];
    fr[8] += {7'h00, bad};
    for (int i = 0; i < 9; i++) begin
      if (!can_mode || (i > 0 && i < 8)) begin
        @(negedge core_clk);
        rx_valid = 1'b1;
        rx_byte = fr[i];
        rx_frame_start = (i == (can_mode ? 1 : 0));
      end
    end
    @(negedge core_clk);
    rx_valid = 1'b0;
    rx_frame_start = 1'b0;
    rx_byte = ~rx_byte;
    if (!can_mode && a != module_addr) begin
      repeat (30) begin
        @(negedge core_clk);
        `CHK("tx_valid after foreign frame", 1'b0, tx_valid)
      end
      return;
    end
    n = 0;
    while (!bad && n < 6 && cmd_valid !== 1'b1) begin
      @(negedge core_clk);
      n++;
    end
    if (!bad) `CHK("cmd_valid", 1'b1, cmd_valid)
    if (!bad) `CHK("command fields", {c, t, b, v}, {cmd_number, cmd_type, cmd_bank, cmd_value})
    rv = bad ? 32'h0 : exec_value;
    e = {bad ? 8'h01 : status_of(r), c, rv[31:24], rv[23:16], rv[15:8], rv[7:0]};
    if (!can_mode) begin
      e = {reply_addr, module_addr, e};
      ck = 8'h00;
      foreach (e[k]) ck += e[k];
      e.push_back(ck);
    end
    n = 0;
    ck = 8'h00;
    while (n < 300 && ck == 8'h00) begin
      @(negedge core_clk);
      tx_ready = 1'($urandom);
      `CHK("tx_drive", tx_valid, tx_drive)
      if (tx_valid === 1'b1 && tx_ready) begin
        got.push_back(tx_byte);
        ck = {7'h00, tx_last === 1'b1};
      end
      n++;
    end
    @(negedge core_clk);
    tx_ready = 1'b0;
    `CHK("tx_valid after reply", 1'b0, tx_valid)
    `CHK("reply length", e.size(), got.size())
    `CHK("status", e[can_mode ? 0 : 2], got[can_mode ? 0 : 2])
    foreach (e[k]) `CHK("reply byte", e[k], got[k])
  endtask : run
  initial begin
    rst = 1'b1;
    can_mode = 1'b0;
    module_addr = 8'h2a;
    reply_addr = 8'h05;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rx_frame_start = 1'b0;
    tx_ready = 1'b0;
    exec_result = BCFI_RES_OK;
    exec_value = 32'h0;
    dly = 8'h01;
    void'($urandom(32'h67a8));
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 14; i++) begin
      run(module_addr, 8'($urandom), 8'($urandom), 8'($urandom), $urandom, 1'b0, bcfi_result_t'(i % 7));
    end
    run(module_addr, 8'h06, 8'hff, 8'h00, 32'hffffffff, 1'b1, BCFI_RES_OK);
    run(module_addr + 8'h01, 8'h05, 8'h04, 8'h00, 32'h00000100, 1'b0, BCFI_RES_OK);
    can_mode = 1'b1;
    for (int i = 0; i < 4; i++) begin
      run(8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), $urandom, 1'b0, bcfi_result_t'(i));
    end
    can_mode = 1'b0;
    run(module_addr, 8'h01, 8'h00, 8'h00, 32'h80000001, 1'b0, BCFI_RES_OK);
    summarize();
  end
endmodule : tb_top
